// ===== rtl/irq_ctrl_pkg.sv
// Constants and types shared by the I/O subsystem interrupt collector
package irq_ctrl_pkg;

    // Register and bus widths
    localparam int DATA_W = 32;
    localparam int IRQ_W = 15;

    // Register byte addresses
    localparam logic [31:0] ADDR_REQUEST = 32'h0008_0000;
    localparam logic [31:0] ADDR_MASK = 32'h0008_0004;
    localparam logic [31:0] ADDR_PENDING = 32'h0008_0008;

    // Reset values
    localparam logic [IRQ_W-1:0] MASK_RST = 15'h0000;
    localparam logic [IRQ_W-1:0] PEND_RST = 15'h0000;

    // Active level per source, one means active high; register bit i
    // carries documented bit 31-i, so bits 1, 5 and 6 are active high
    localparam logic [IRQ_W-1:0] ACTIVE_HIGH = 15'h0062;

    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Which register an address phase selects
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_REQUEST = 2'b01,
        SEL_MASK = 2'b10,
        SEL_PENDING = 2'b11
    } reg_sel_t;

endpackage

// ===== rtl/irq_edge_sync.sv
// Synchroniser and active-edge detector for the interrupt input lines
`timescale 1ns/1ps
`default_nettype none
module irq_edge_sync #(
    parameter int W = 15,
    parameter logic [W-1:0] ACT_HIGH = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Lines from the devices and detected edges
    input wire logic [W-1:0] lines_in,
    output logic [W-1:0] rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] last;
    } sync_t;

    sync_t s_r;
    sync_t s_nxt;

    // Level seen as active after polarity correction
    function automatic logic [W-1:0] active_of(input logic [W-1:0] v);
        active_of = ~(v ^ ACT_HIGH);
    endfunction

    // Two flops before any logic; a line held active through reset fires nothing
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.s1 = lines_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.last = s_r.s2;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r <= {3{ACT_HIGH}};
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Transition into the active level, one cycle pulse
    assign rise = active_of(s_r.s2) & ~active_of(s_r.last);

    a_edge_level: assert property (@(posedge clk) disable iff (!rst_n)
        (rise != '0) |-> (((~($past(lines_in, 2) ^ ACT_HIGH)) & rise) == rise)
            && ((($past(lines_in, 3) ^ ACT_HIGH) & rise) == rise))
        else $error("Edge reported without inactive-to-active pin change");

endmodule
`default_nettype wire

// ===== rtl/io_subsystem_irq_ctrl.sv
// Interrupt collector of the I/O subsystem with AHB-Lite register access
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module io_subsystem_irq_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Subsystem reset strobe from the reset register, same clock
    input wire logic subsys_reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [irq_ctrl_pkg::DATA_W-1:0] hwdata,
    output logic [irq_ctrl_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Device interrupt lines, bit i is documented source 31-i
    input wire logic [irq_ctrl_pkg::IRQ_W-1:0] io_irq_in,
    // Interrupt request to the host controller
    output logic host_irq
);
    import irq_ctrl_pkg::*;

    // Reset release synchroniser
    logic rst_q1;
    logic rst_n;

    // Reset asserts at once and releases two edges later
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // Whole state of the collector
    typedef struct packed {
        logic [IRQ_W-1:0] mask;
        logic [IRQ_W-1:0] pending;
        reg_sel_t wr_sel;
        logic [DATA_W-1:0] rdata;
        logic ready;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Detected active edges, one pulse per edge
    logic [IRQ_W-1:0] rise;

    // Decode helpers
    logic addr_ok;
    reg_sel_t addr_sel;
    logic [IRQ_W-1:0] ack_bits;
    logic clr_all;

    // Register selected by a bus address
    function automatic reg_sel_t decode(input logic [31:0] a);
        if (a == ADDR_REQUEST)
        begin
            decode = SEL_REQUEST;
        end
        else if (a == ADDR_MASK)
        begin
            decode = SEL_MASK;
        end
        else if (a == ADDR_PENDING)
        begin
            decode = SEL_PENDING;
        end
        else
        begin
            decode = SEL_NONE;
        end
    endfunction

    // Upper bits of every register read as zero
    function automatic logic [DATA_W-1:0] widen(input logic [IRQ_W-1:0] v);
        widen = {{(DATA_W - IRQ_W){1'b0}}, v};
    endfunction

    // Input synchroniser and edge detection
    irq_edge_sync #(
        .W(IRQ_W),
        .ACT_HIGH(ACTIVE_HIGH)
    ) u_edge (
        .clk(ref_clk),
        .rst_n(rst_n),
        .lines_in(io_irq_in),
        .rise(rise)
    );

    // Address phase qualification
    assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign addr_sel = decode(haddr);

    // Next state: bus decode, pending update and request line
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.wr_sel = SEL_NONE;
        s_nxt.rdata = '0;
        s_nxt.ready = 1'b1;
        ack_bits = '0;
        clr_all = (s_r.wr_sel == SEL_PENDING);

        // Reads answer in the data phase from the register set here
        if (addr_ok && !hwrite)
        begin
            unique case (addr_sel)
                SEL_REQUEST:
                begin
                    s_nxt.rdata = widen(s_r.pending & s_r.mask);
                    ack_bits = s_r.pending & s_r.mask;
                end
                SEL_MASK:
                begin
                    s_nxt.rdata = widen(s_r.mask);
                end
                SEL_PENDING:
                begin
                    s_nxt.rdata = widen(s_r.pending);
                end
                SEL_NONE:
                begin
                    s_nxt.rdata = '0;
                end
            endcase
        end

        // Mask and pending writes are remembered until their data phase; sub-word writes are
        // dropped since software only issues whole words
        if (addr_ok && hwrite && hsize == HSIZE_WORD)
        begin
            if (addr_sel == SEL_MASK || addr_sel == SEL_PENDING)
            begin
                s_nxt.wr_sel = addr_sel;
            end
        end

        // Mask write keeps only the implemented bits
        if (s_r.wr_sel == SEL_MASK)
        begin
            s_nxt.mask = hwdata[IRQ_W-1:0];
        end

        // Pending write clears all and beats a coinciding edge; otherwise a
        // new edge wins over the acknowledge of a request read
        if (clr_all)
        begin
            s_nxt.pending = '0;
        end
        else
        begin
            s_nxt.pending = (s_r.pending & ~ack_bits) | rise;
        end

        // Subsystem reset returns mask and pending to power-up state
        if (subsys_reset)
        begin
            s_nxt.mask = MASK_RST;
            s_nxt.pending = PEND_RST;
        end

        // Request line follows the unmasked pending set
        s_nxt.irq = |(s_nxt.pending & s_nxt.mask);
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_r.mask <= MASK_RST;
            s_r.pending <= PEND_RST;
            s_r.wr_sel <= SEL_NONE;
            s_r.rdata <= '0;
            s_r.ready <= 1'b1;
            s_r.irq <= 1'b0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops, hresp tied to OKAY; the slave never stalls or errors
    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.ready;
    assign hresp = HRESP_OKAY;
    assign host_irq = s_r.irq;

    // Helper terms for the checks below
    logic rd_request;
    logic rd_pending;
    logic wr_pend_data;
    logic [IRQ_W-1:0] requests;

    assign rd_request = addr_ok && !hwrite && addr_sel == SEL_REQUEST;
    assign rd_pending = addr_ok && !hwrite && addr_sel == SEL_PENDING;
    assign wr_pend_data = (s_r.wr_sel == SEL_PENDING);
    assign requests = s_r.pending & s_r.mask;

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (!rst_n);

    a_upper_bits_zero: assert property (
        hrdata[DATA_W-1:IRQ_W] == '0)
        else $error("Unimplemented register bits read as nonzero");

    a_mask_write_width: assert property (
        (s_r.wr_sel == SEL_MASK && !subsys_reset) |=> s_r.mask == $past(hwdata[IRQ_W-1:0]))
        else $error("Mask write did not take the low data bits");

    a_edge_sets_pend: assert property (
        (rise != '0 && !wr_pend_data && !subsys_reset) |=> ($past(rise) & ~s_r.pending) == '0)
        else $error("Active edge failed to set its pending bit");

    a_pend_read_keeps: assert property (
        (rd_pending && !wr_pend_data && !subsys_reset)
            |=> hrdata == widen($past(s_r.pending)) && ($past(s_r.pending) & ~s_r.pending) == '0)
        else $error("Pending read returned wrong data or changed bits");

    a_pend_write_clear: assert property (
        (addr_ok && hwrite && hsize == HSIZE_WORD && addr_sel == SEL_PENDING)
            |=> ##1 s_r.pending == '0)
        else $error("Pending write did not clear the register");

    a_clear_beats_edge: assert property (
        (wr_pend_data && rise != '0) |=> s_r.pending == '0)
        else $error("Edge during pending write left a bit set");

    a_request_data: assert property (
        rd_request |=> hrdata == widen($past(requests)))
        else $error("Request read data differs from pending and mask");

    a_irq_follows: assert property (
        host_irq == (requests != '0))
        else $error("Interrupt output disagrees with the request set");

    a_irq_holds: assert property (
        (host_irq && !rd_request && !subsys_reset && s_r.wr_sel == SEL_NONE) |=> host_irq)
        else $error("Interrupt output dropped without an acknowledge");

    a_read_acks: assert property (
        rd_request |=> (s_r.pending & $past(requests) & ~$past(rise)) == '0)
        else $error("Request read left unmasked pending bits set");

    a_masked_stays: assert property (
        (!wr_pend_data && !subsys_reset) |=> ($past(s_r.pending & ~s_r.mask) & ~s_r.pending) == '0)
        else $error("Masked pending bit was lost");

    a_reset_clean: assert property (
        $rose(rst_n) |-> s_r.mask == '0 && s_r.pending == '0 && !host_irq)
        else $error("State not clean after reset release");

    a_subsys_reset: assert property (
        subsys_reset |=> s_r.mask == MASK_RST && s_r.pending == PEND_RST && !host_irq)
        else $error("Subsystem reset left state behind");

    a_bus_ready: assert property (
        hreadyout && hresp == HRESP_OKAY)
        else $error("Slave stalled or answered with an error");

endmodule
`default_nettype wire

// ===== bench/irq_source_model.sv
// Behavioural model of the devices that drive the interrupt lines
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    // Clock
    input wire logic ref_clk,
    // One-cycle fire request per line from the bench
    input wire logic [irq_ctrl_pkg::IRQ_W-1:0] fire,
    // Device interrupt lines
    output logic [irq_ctrl_pkg::IRQ_W-1:0] lines
);
    import irq_ctrl_pkg::*;

    logic [IRQ_W-1:0] act1_r = '0;
    logic [IRQ_W-1:0] act2_r = '0;

    // Two cycles active outlasts one subsystem cycle, so the synchroniser sees it
    always_ff @(posedge ref_clk)
    begin
        act1_r <= fire;
        act2_r <= act1_r;
    end

    // Lines idle at the inverse of their active level between pulses
    assign lines = ~((act1_r | act2_r) ^ ACTIVE_HIGH);
endmodule
`default_nettype wire

// ===== bench/test_io_subsystem_irq_ctrl.sv
// Self-checking testbench for the interrupt collector
`timescale 1ns/1ps
`default_nettype none
module test_io_subsystem_irq_ctrl;
    import irq_ctrl_pkg::*;

    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic subsys_reset = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    wire logic hreadyout;
    logic [IRQ_W-1:0] fire = '0;
    wire logic [IRQ_W-1:0] lines;
    int n_fail = 0;
    int comparisons = 0;

    // Free-running 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    io_subsystem_irq_ctrl dut (
        .ref_clk(ref_clk), .resetn(resetn), .subsys_reset(subsys_reset),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .io_irq_in(lines), .host_irq()
    );

    irq_source_model src (.ref_clk(ref_clk), .fire(fire), .lines(lines));

    // Compare one value and count it
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // One whole-word AHB-Lite transfer; waits on hready at both phases
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Read a register and compare the word
    task automatic rchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, exp, rd);
    endtask

    // Pulse the device lines, then let the edges reach the pending register
    task automatic pulse(input logic [IRQ_W-1:0] f);
        fire <= f;
        @(posedge ref_clk);
        fire <= '0;
        repeat (8) @(posedge ref_clk);
    endtask

    // Check the interrupt output as registered in the previous cycle
    task automatic irq(input logic exp);
        @(posedge ref_clk);
        chk("host_irq", {31'h0, exp}, {31'h0, dut.host_irq});
    endtask

    // Verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog sized well above the hundred or so cycles the tests need
    initial
    begin
        #100us;
        n_fail++;
        stop_test();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rchk("request", ADDR_REQUEST, 32'h0);
        rchk("mask", ADDR_MASK, 32'h0);
        rchk("pending", ADDR_PENDING, 32'h0);
        bus(1'b1, ADDR_MASK, 32'hffff_ffff);
        rchk("mask", ADDR_MASK, 32'h0000_7fff);
        rchk("unmapped", 32'h0008_000c, 32'h0);
        bus(1'b1, ADDR_MASK, 32'h0);
        $display("test registers done");
        // Every source fires at its own level while all are masked
        pulse(15'h7fff);
        irq(1'b0);
        rchk("pending", ADDR_PENDING, 32'h0000_7fff);
        rchk("pending", ADDR_PENDING, 32'h0000_7fff);
        rchk("request", ADDR_REQUEST, 32'h0);
        bus(1'b1, ADDR_MASK, 32'h0000_0001);
        irq(1'b1);
        irq(1'b1);
        rchk("request", ADDR_REQUEST, 32'h0000_0001);
        irq(1'b0);
        rchk("request", ADDR_REQUEST, 32'h0);
        rchk("pending", ADDR_PENDING, 32'h0000_7ffe);
        bus(1'b1, ADDR_PENDING, 32'h0000_1234);
        rchk("pending", ADDR_PENDING, 32'h0);
        $display("test edges and acknowledge done");
        // Request register is read-only; subsystem reset clears mask and pending
        bus(1'b1, ADDR_MASK, 32'h0000_7fff);
        pulse(15'h4021);
        bus(1'b1, ADDR_REQUEST, 32'h0);
        rchk("request", ADDR_REQUEST, 32'h0000_4021);
        pulse(15'h0102);
        irq(1'b1);
        subsys_reset <= 1'b1;
        @(posedge ref_clk);
        subsys_reset <= 1'b0;
        irq(1'b0);
        rchk("mask", ADDR_MASK, 32'h0);
        rchk("pending", ADDR_PENDING, 32'h0);
        $display("test subsystem reset done");
        stop_test();
    end
endmodule
`default_nettype wire
